// ### hw/utmi_port_pkg.sv
package utmi_port_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ     = 250;
  localparam int LINK_MHZ    = 60;
  localparam int DIV_HALF    = (CLK_MHZ / (2 * LINK_MHZ) < 1) ? 1 : CLK_MHZ / (2 * LINK_MHZ);
  localparam int SYNC_TICKS  = 4;
  localparam int EOP_TICKS   = 2;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] XCVR_HS      = 2'h0;
  localparam logic [1:0] XCVR_FS      = 2'h1;
  localparam logic [1:0] XCVR_LS      = 2'h2;
  localparam logic [1:0] XCVR_LS_FSE  = 2'h3;
  localparam logic [1:0] OPM_NORMAL   = 2'h0;
  localparam logic [1:0] OPM_NONDRIVE = 2'h1;
  localparam logic [1:0] OPM_BYPASS   = 2'h2;
  localparam logic [1:0] AXI_OKAY     = 2'h0;
  localparam logic [1:0] AXI_SLVERR   = 2'h2;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_TXDATA   = 8'h08;
  localparam logic [7:0] REG_RXDATA   = 8'h0c;
  localparam logic [7:0] REG_EVENT    = 8'h10;
  localparam int         CTRL_HOST    = 0;
  localparam int         RX_LAST      = 8;
  localparam int         EVT_DISC     = 0;
  localparam logic       HOST_RST     = 1'h0;
  localparam logic       ID_RST       = 1'h1;
  typedef struct packed {
    logic       hostDisc;
    logic       idDig;
    logic       rxFull;
    logic       txReady;
    logic       rxActive;
    logic       linkRst;
    logic       txValid;
    logic       suspended;
    logic [1:0] opMode;
    logic       termSel;
    logic [1:0] xcvrSel;
  } status_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_SYNC = 4'h2, TX_DATA = 4'h4, TX_EOP = 4'h8
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1, RX_ACTIVE = 3'h2, RX_END = 3'h4
  } rx_state_t;
endpackage : utmi_port_pkg

// ### hw/reg_bus_if.sv
`timescale 1ns/1ns
interface reg_bus_if;
  logic        wrEn;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrHit;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  logic        rdHit;
  modport slave (output wrEn, wrAddr, wrData, wrStrb, rdAddr,
                 input  wrHit, rdData, rdHit);
  modport regs  (input  wrEn, wrAddr, wrData, wrStrb, rdAddr,
                 output wrHit, rdData, rdHit);
endinterface : reg_bus_if

// ### hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // System
  input  wire logic             clock,
  input  wire logic             srst,
  // Pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;
  sync_state_t q;
  sync_state_t d;
  // A bit only moves once two later stages agree, so a metastable
  // first stage never reaches the output directly.
  always_comb begin
    d    = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.out[i] = q.s3[i];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= {INIT, INIT, INIT, INIT};
    end else begin
      q <= d;
    end
  end
  assign synced = q.out;
endmodule : pin_sync

// ### hw/axi_lite_slave.sv
`timescale 1ns/1ns
module axi_lite_slave
  import utmi_port_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        srst,
  // Write channels
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  // Read channels
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // Register side
  reg_bus_if.slave         bus
);
  typedef struct packed {
    logic        awHave;
    logic        wHave;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_state_t;
  axi_state_t q;
  axi_state_t d;
  assign awready    = ~q.awHave & ~q.bvalid;
  assign wready     = ~q.wHave & ~q.bvalid;
  assign arready    = ~q.rvalid;
  assign bus.wrEn   = q.awHave & q.wHave;
  assign bus.wrAddr = q.addr;
  assign bus.wrData = q.data;
  assign bus.wrStrb = q.strb;
  assign bus.rdAddr = araddr;
  always_comb begin
    d = q;
    if (awvalid && awready) begin
      d.awHave = 1'b1;
      d.addr   = awaddr;
    end
    if (wvalid && wready) begin
      d.wHave = 1'b1;
      d.data  = wdata;
      d.strb  = wstrb;
    end
    if (q.awHave && q.wHave) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = bus.wrHit ? AXI_OKAY : AXI_SLVERR;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata  = bus.rdData;
      d.rresp  = bus.rdHit ? AXI_OKAY : AXI_SLVERR;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign bvalid = q.bvalid;
  assign bresp  = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata  = q.rdata;
  assign rresp  = q.rresp;
endmodule : axi_lite_slave

// ### hw/utmi_link_port.sv
// Functional notes
// - Transceiver select: 00 HS, 01 FS, 10 LS, 11 LS data with FS edges.
// - Termination select low enables HS termination, high enables FS termination.
// - Transmit ready acknowledges each byte taken into the holding register.
// - Transmit valid rising starts SYNC; falling starts end-of-packet.
// - Suspend input low enters low-power suspend and stops clocks; high runs.
// - Host-mode suspend removes pull-up; device pull-down follows termination select.
// - Charge input high connects VBUS charging resistor; low disconnects it.
// - Receive active rises on start of packet and holds during reception.
// - Operating mode: 0 normal, 1 non-driving no terminations, 2 coding bypass.
// - ID output reports sampled ID pin: 0 mini-A, 1 mini-B.
// - ID pull-up input high enables ID sampling, low disables sampler.
// - Block supplies the link clock and drives txReady, rxActive, rxValid and dataOut on it.
// - Line state bit 0 follows D+, bit 1 follows D-.
// - Line state codes: SE0 0, J 1, K 2, SE1 3.
// - Line state is combinational in suspend, synchronised to link clock otherwise.
// - Data bus is eight bits, bidirectional, bit 7 most significant.
// - Host disconnect flags device removal in HS host mode and clears on entering low power.
`timescale 1ns/1ns
module utmi_link_port
  import utmi_port_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        srst,
  // Register bus
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // Link control pins
  input  wire logic [1:0]  xcvrSel,
  input  wire logic        termSel,
  input  wire logic [1:0]  opMode,
  input  wire logic        suspend_n,
  input  wire logic        txValid,
  input  wire logic        linkReset,
  input  wire logic        chargeVbus,
  input  wire logic        idPullup,
  // Data bus
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic             dataOe,
  // Link status pins
  output logic             clkOut,
  output logic             txReady,
  output logic             rxActive,
  output logic             rxValid,
  output logic      [1:0]  lineState,
  output logic             idDig,
  output logic             hostDisc,
  // Cable side
  input  wire logic        dpIn,
  input  wire logic        dmIn,
  input  wire logic        idIn,
  // Analog front-end controls
  output logic             hsTermEn,
  output logic             fsTermEn,
  output logic             pullupEn,
  output logic             pulldownEn,
  output logic             chargePathEn,
  output logic             idSamplerEn,
  output logic             usbDriveEn,
  output logic             sendSync,
  output logic             sendEop,
  output logic             bypassCoding,
  output logic             speedHs,
  output logic             speedFs,
  output logic             speedLs,
  output logic             fsEdgeRate
);
  // ----------------------------------------
  // Pin synchronisers and register bus
  // ----------------------------------------
  localparam int         SYNC_W    = 21;
  localparam int         DIV_W     = $clog2(DIV_HALF + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_HALF - 1);
  localparam logic [2:0] SYNC_LAST = 3'(SYNC_TICKS - 1);
  localparam logic [2:0] EOP_LAST  = 3'(EOP_TICKS - 1);
  localparam logic [SYNC_W-1:0] SYNC_INIT = 21'h000020;
  logic [SYNC_W-1:0] syncOut;
  logic [1:0]        xcvrS, opS;
  logic [7:0]        dataS;
  logic              termS, suspNS, txValidS, linkRst, chargeS, idPullS, dpS, dmS, idS;
  reg_bus_if         bus ();
  pin_sync #(.WIDTH (SYNC_W), .INIT (SYNC_INIT)) u_pin_sync (
    .clock, .srst,
    .pinIn  ({dataIn, idIn, dmIn, dpIn, idPullup, chargeVbus, linkReset,
              txValid, suspend_n, opMode, termSel, xcvrSel}),
    .synced (syncOut)
  );
  assign {dataS, idS, dmS, dpS, idPullS, chargeS, linkRst,
          txValidS, suspNS, opS, termS, xcvrS} = syncOut;
  axi_lite_slave u_axi (
    .clock, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .bus (bus)
  );
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             clkOut;
    logic             hostMode;
    tx_state_t        txState;
    logic [2:0]       txCnt;
    logic [7:0]       txByte;
    logic             txReady;
    rx_state_t        rxState;
    logic             rxFull;
    logic [7:0]       rxByte;
    logic             rxLast;
    logic             rxValid;
    logic [7:0]       dataOut;
    logic             dataOe;
    logic [1:0]       lineSamp;
    logic             idDig;
    logic             hostDisc;
    logic             suspPrev;
  } port_state_t;
  port_state_t q;
  port_state_t d;
  logic    suspended, tick, nonDrive, wrSel, rxPush, rxTake, discSet, suspRise;
  status_t status;
  assign suspended = ~suspNS;
  assign nonDrive  = (opS == OPM_NONDRIVE);
  // Link clock rises when the high half starts; suspend freezes it low.
  assign tick      = ~suspended & ~q.clkOut & (q.div == DIV_LAST);
  assign wrSel     = bus.wrEn & bus.wrStrb[0];
  assign rxTake    = tick & ~linkRst & (q.rxState == RX_ACTIVE) & q.rxFull;
  assign rxPush    = wrSel & (bus.wrAddr == REG_RXDATA) & (~q.rxFull | rxTake);
  assign discSet   = wrSel & (bus.wrAddr == REG_EVENT) & bus.wrData[EVT_DISC]
                     & q.hostMode & (xcvrS == XCVR_HS);
  assign suspRise  = suspended & ~q.suspPrev;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d          = q;
    d.suspPrev = suspended;
    if (suspended) begin
      d.div    = '0;
      d.clkOut = 1'b0;
    end else if (q.div == DIV_LAST) begin
      d.div    = '0;
      d.clkOut = ~q.clkOut;
    end else begin
      d.div = q.div + DIV_W'(1);
    end
    if (wrSel && bus.wrAddr == REG_CTRL) begin
      d.hostMode = bus.wrData[CTRL_HOST];
    end
    if (idPullS) begin
      d.idDig = idS;
    end
    // Disconnect event wins over the low-power clear in the same cycle.
    d.hostDisc = discSet | (q.hostDisc & ~suspRise);
    if (tick) begin
      d.lineSamp = {dmS, dpS};
    end
    if (rxTake) begin
      d.rxFull = 1'b0;
    end
    if (rxPush) begin
      d.rxFull = 1'b1;
      d.rxByte = bus.wrData[7:0];
      d.rxLast = bus.wrData[RX_LAST];
    end
    if (linkRst) begin
      d.txState = TX_IDLE;
      d.txCnt   = '0;
      d.txReady = 1'b0;
      d.rxState = RX_IDLE;
      d.rxValid = 1'b0;
    end else if (tick) begin
      unique case (q.txState)
        TX_IDLE: begin
          d.txReady = 1'b0;
          if (txValidS && !nonDrive) begin
            d.txState = TX_SYNC;
            d.txCnt   = '0;
          end
        end
        TX_SYNC: begin
          if (!txValidS) begin
            d.txState = TX_EOP;
            d.txCnt   = '0;
          end else if (q.txCnt == SYNC_LAST) begin
            d.txState = TX_DATA;
          end else begin
            d.txCnt = q.txCnt + 3'h1;
          end
        end
        TX_DATA: begin
          if (txValidS) begin
            d.txByte  = dataS;
            d.txReady = 1'b1;
          end else begin
            d.txReady = 1'b0;
            d.txState = TX_EOP;
            d.txCnt   = '0;
          end
        end
        TX_EOP: begin
          if (q.txCnt == EOP_LAST) begin
            d.txState = TX_IDLE;
          end else begin
            d.txCnt = q.txCnt + 3'h1;
          end
        end
      endcase
      unique case (q.rxState)
        RX_IDLE: begin
          d.rxValid = 1'b0;
          if (q.rxFull) begin
            d.rxState = RX_ACTIVE;
          end
        end
        RX_ACTIVE: begin
          d.rxValid = q.rxFull;
          if (q.rxFull) begin
            d.dataOut = q.rxByte;
            if (q.rxLast) begin
              d.rxState = RX_END;
            end
          end
        end
        RX_END: begin
          d.rxValid = 1'b0;
          d.rxState = RX_IDLE;
        end
      endcase
    end
    // The bus turns round only while receiving and the link is not sending.
    d.dataOe = (d.rxState != RX_IDLE) & ~txValidS;
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      q          <= '0;
      q.hostMode <= HOST_RST;
      q.txState  <= TX_IDLE;
      q.rxState  <= RX_IDLE;
      q.idDig    <= ID_RST;
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------
  // Register read and decode
  // ----------------------------------------
  assign status = '{hostDisc: q.hostDisc, idDig: q.idDig, rxFull: q.rxFull,
                    txReady: q.txReady, rxActive: (q.rxState != RX_IDLE),
                    linkRst: linkRst, txValid: txValidS, suspended: suspended,
                    opMode: opS, termSel: termS, xcvrSel: xcvrS};
  always_comb begin
    bus.rdHit  = 1'b1;
    bus.rdData = '0;
    unique case (bus.rdAddr)
      REG_CTRL:   bus.rdData[CTRL_HOST] = q.hostMode;
      REG_STATUS: bus.rdData = 32'(status);
      REG_TXDATA: bus.rdData[7:0] = q.txByte;
      REG_RXDATA: bus.rdData[8:0] = {q.rxLast, q.rxByte};
      REG_EVENT:  bus.rdData = '0;
      default:    bus.rdHit = 1'b0;
    endcase
  end
  assign bus.wrHit = (bus.wrAddr == REG_CTRL) | (bus.wrAddr == REG_STATUS)
                   | (bus.wrAddr == REG_TXDATA) | (bus.wrAddr == REG_RXDATA)
                   | (bus.wrAddr == REG_EVENT);
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign clkOut       = q.clkOut;
  assign txReady      = q.txReady;
  assign rxActive     = (q.rxState != RX_IDLE);
  assign rxValid      = q.rxValid;
  assign dataOut      = q.dataOut;
  assign dataOe       = q.dataOe;
  // Raw pins in suspend: the link clock is stopped then, so no sampling.
  assign lineState    = suspended ? {dmIn, dpIn} : q.lineSamp;
  assign idDig        = q.idDig;
  assign hostDisc     = q.hostDisc;
  assign hsTermEn     = ~termS & ~nonDrive;
  assign fsTermEn     = termS & ~nonDrive;
  assign pullupEn     = termS & ~nonDrive & ~(q.hostMode & suspended);
  assign pulldownEn   = ~nonDrive & (q.hostMode | termS);
  assign chargePathEn = chargeS;
  assign idSamplerEn  = idPullS;
  assign usbDriveEn   = ~nonDrive & (q.txState != TX_IDLE);
  assign sendSync     = (q.txState == TX_SYNC);
  assign sendEop      = (q.txState == TX_EOP);
  assign bypassCoding = (opS == OPM_BYPASS);
  assign speedHs      = (xcvrS == XCVR_HS);
  assign speedFs      = (xcvrS == XCVR_FS);
  assign speedLs      = xcvrS[1];
  assign fsEdgeRate   = (xcvrS == XCVR_FS) | (xcvrS == XCVR_LS_FSE);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence txStart;
    tick && !linkRst && q.txState == TX_IDLE && txValidS && !nonDrive;
  endsequence
  sequence txStop;
    tick && !linkRst && q.txState == TX_DATA && !txValidS;
  endsequence
  sequence syncPhase;
    sendSync && !linkRst;
  endsequence
  a_speed_decode: assert property (speedLs |-> !speedHs && !speedFs)
    else $error("speed decode overlaps");
  a_term_select: assert property (hsTermEn |-> !termS && !fsTermEn)
    else $error("both terminations selected");
  a_ready_in_data: assert property ($rose(txReady) |-> $past(q.txState) == TX_DATA)
    else $error("txReady outside data phase");
  a_sync_start: assert property (txStart |=> syncPhase)
    else $error("SYNC did not start");
  a_eop_start: assert property (txStop |=> sendEop && !txReady)
    else $error("EOP did not start");
  a_suspend_clock: assert property (suspended [*2] |-> !clkOut && !tick)
    else $error("link clock runs in suspend");
  a_host_pullup: assert property (q.hostMode && suspended |-> !pullupEn)
    else $error("pull-up kept in host suspend");
  a_reset_idle: assert property (linkRst |=> !sendSync && !rxActive && !txReady)
    else $error("state machine not idle after reset");
  a_charge_path: assert property ($rose(chargeS) |-> chargePathEn)
    else $error("charge path missing");
  a_rx_active: assert property (rxValid |-> rxActive && $past(rxActive))
    else $error("rxValid without rxActive");
  a_nondrive_mode: assert property (nonDrive |-> !usbDriveEn && !pulldownEn)
    else $error("drive in non-driving mode");
  a_id_hold: assert property (!idPullS ##1 !idPullS |-> $stable(idDig))
    else $error("ID changed with sampler off");
  a_clock_period: assert property ($rose(clkOut) && !suspended |=> clkOut)
    else $error("link clock high phase short");
  a_line_suspend: assert property (suspended |-> lineState == {dmIn, dpIn})
    else $error("line state not direct in suspend");
  a_disc_clear: assert property (suspRise && !discSet |=> !hostDisc)
    else $error("disconnect kept in low power");
endmodule : utmi_link_port

// ### verif/utmi_link_model.sv
`timescale 1ns/1ns
module utmi_link_model #(
  parameter logic [7:0] TX_BYTE = 8'ha5
) (
  // Link clock
  input  wire logic       clkOut,
  // Commands
  input  wire logic       goTx,
  input  wire logic       rstReq,
  // Pins
  output logic            txValid,
  output logic            linkReset,
  output logic      [7:0] dataIn
);
  logic [2:0] waitQ = 3'h0;
  initial txValid = 1'b0;
  initial linkReset = 1'b0;
  // ----------------------------------------
  // Link clock side
  // ----------------------------------------
  // Only clkOut edges move the pins, so reset never leaves off-edge
  always @(posedge clkOut) begin
    linkReset <= rstReq;
    waitQ     <= linkReset ? 3'h0 : waitQ + 3'(waitQ != 3'h5);
    txValid   <= goTx & ~linkReset & (waitQ == 3'h5);
  end
  // Byte is held for the whole packet; the released bus is pulled low
  assign dataIn = txValid ? TX_BYTE : 8'h00;
endmodule : utmi_link_model

// ### verif/utmi_link_port_tb_top.sv
`timescale 1ns/1ns
module utmi_link_port_tb_top;
  import utmi_port_pkg::*;
  localparam logic [7:0] TXB = 8'ha5;
  logic clock, srst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, termSel, suspend_n, txValid, linkReset, chargeVbus, idPullup;
  logic dataOe, clkOut, txReady, rxActive, rxValid, idDig, hostDisc, dpIn, dmIn, idIn;
  logic hsTermEn, fsTermEn, pullupEn, pulldownEn, chargePathEn, idSamplerEn, usbDriveEn;
  logic sendSync, sendEop, bypassCoding, speedHs, speedFs, speedLs, fsEdgeRate, goTx, rstReq;
  logic [7:0]  awaddr, araddr, dataIn, dataOut;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, xcvrSel, opMode, lineState, r;
  int          errTotal, nChecks;
  utmi_link_port dut (.clock, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .xcvrSel, .termSel, .opMode, .suspend_n, .txValid, .linkReset, .chargeVbus,
    .idPullup, .dataIn, .dataOut, .dataOe, .clkOut, .txReady, .rxActive, .rxValid, .lineState,
    .idDig, .hostDisc, .dpIn, .dmIn, .idIn, .hsTermEn, .fsTermEn, .pullupEn, .pulldownEn,
    .chargePathEn, .idSamplerEn, .usbDriveEn, .sendSync, .sendEop, .bypassCoding, .speedHs,
    .speedFs, .speedLs, .fsEdgeRate);
  utmi_link_model #(.TX_BYTE(TXB)) link (.clkOut, .goTx, .rstReq, .txValid, .linkReset, .dataIn);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      errTotal++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clock);
    bready <= 1'b0; chk(bresp, AXI_OKAY);
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rready <= 1'b0; d = rdata; r = rresp;
    @(posedge clock);
  endtask : rd
  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : endOfTest
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tSel();
    logic [3:0] spd [4] = '{4'h8, 4'h5, 4'h2, 4'h3};
    logic [2:0] mod [3] = '{3'h2, 3'h0, 3'h3};
    for (int i = 0; i < 4; i++) begin
      xcvrSel <= 2'(i); cyc(10);
      chk({speedHs, speedFs, speedLs, fsEdgeRate}, spd[i]);
    end
    for (int i = 0; i < 2; i++) begin
      termSel <= i[0]; cyc(10);
      chk({hsTermEn, fsTermEn}, {~i[0], i[0]});
    end
    // Mode 3 is never driven
    for (int i = 0; i < 3; i++) begin
      opMode <= 2'(i); cyc(10);
      chk({hsTermEn, fsTermEn, bypassCoding}, mod[i]);
    end
    opMode <= OPM_NORMAL; xcvrSel <= XCVR_HS; cyc(10);
    $display("Select test done");
  endtask : tSel
  task automatic tPins();
    for (int i = 0; i < 2; i++) begin
      chargeVbus <= i[0]; idPullup <= i[0]; cyc(10);
      chk({chargePathEn, idSamplerEn}, {i[0], i[0]});
    end
    for (int i = 0; i < 2; i++) begin
      idIn <= i[0]; cyc(24);
      chk(idDig, i[0]);
    end
    for (int i = 0; i < 4; i++) begin
      {dmIn, dpIn} <= 2'(i); cyc(24);
      chk(lineState, i);
    end
    $display("Pin test done");
  endtask : tPins
  task automatic tSusp();
    int hi;
    hi = 0;
    wr(REG_CTRL, 32'h1); wr(REG_EVENT, 32'h1); cyc(4);
    chk(hostDisc, 1);
    suspend_n <= 1'b0; cyc(10);
    chk({hostDisc, pullupEn}, 0);
    for (int i = 0; i < 16; i++) begin
      cyc(1); hi += clkOut;
    end
    chk(hi, 0);
    {dmIn, dpIn} <= 2'h2;
    cyc(1);
    chk(lineState, 2);
    wr(REG_CTRL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      termSel <= i[0]; cyc(10);
      chk(pulldownEn, i[0]);
    end
    suspend_n <= 1'b1; cyc(24);
    $display("Suspend test done");
  endtask : tSusp
  task automatic tTx();
    goTx <= 1'b1;
    for (int n = 0; n < 99 && !sendSync; n++) cyc(1);
    chk(sendSync, 1);
    for (int n = 0; n < 99 && !txReady; n++) cyc(1);
    cyc(8);
    chk(txReady, 1);
    rd(REG_TXDATA); chk(d[7:0], TXB);
    goTx <= 1'b0;
    for (int n = 0; n < 99 && !sendEop; n++) cyc(1);
    chk(sendEop, 1);
    for (int n = 0; n < 99 && usbDriveEn; n++) cyc(1);
    chk(usbDriveEn, 0);
    goTx <= 1'b1;
    for (int n = 0; n < 99 && !sendSync; n++) cyc(1);
    rstReq <= 1'b1; goTx <= 1'b0; cyc(24);
    chk({sendSync, sendEop, usbDriveEn, txReady}, 0);
    rstReq <= 1'b0; cyc(40);
    $display("Transmit test done");
  endtask : tTx
  task automatic tRx();
    wr(REG_RXDATA, 32'h5a);
    for (int n = 0; n < 99 && !rxActive; n++) cyc(1);
    chk({rxActive, dataOe}, 2'h3);
    for (int n = 0; n < 99 && !rxValid; n++) cyc(1);
    chk({rxValid, dataOut}, 9'h15a);
    cyc(4); wr(REG_RXDATA, 32'h1c3);
    for (int n = 0; n < 99 && !(rxValid && dataOut == 8'hc3); n++) cyc(1);
    chk({rxActive, dataOut}, 9'h1c3);
    for (int n = 0; n < 99 && rxActive; n++) cyc(1);
    chk(rxActive, 0);
    rd(REG_CTRL); chk({r, d}, 0);
    rd(8'h40); chk(r, AXI_SLVERR);
    $display("Receive test done");
  endtask : tRx
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #200000 errTotal++;
    endOfTest();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, goTx, rstReq, chargeVbus, idPullup} = '0;
    {xcvrSel, termSel, opMode, dmIn} = '0;
    {srst, suspend_n, dpIn, idIn} = 4'hf;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    errTotal = 0; nChecks = 0;
    cyc(6); srst <= 1'b0; cyc(1);
    chk({idDig, bvalid, rvalid, txReady, rxActive}, 5'h10);
    tSel(); tPins(); tSusp(); tTx(); tRx();
    endOfTest();
  end
endmodule : utmi_link_port_tb_top
